// *** ssr_consts.svh ***
// timing and reset constants for the supply supervisor reset block
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH
`define SSR_CLK_HZ 125000000
`define SSR_STRETCH_MS 140
// least time: rounded up to whole cycles
`define SSR_STRETCH_CYC ((`SSR_STRETCH_MS * 64'd125000000 + 64'd999) / 64'd1000)
`define SSR_DEBOUNCE_US 1
`define SSR_DEBOUNCE_CYC ((`SSR_DEBOUNCE_US * 125000000 + 999999) / 1000000)
`define SSR_CNT_W 32
`define SSR_DB_W 8
`endif

// *** ssr_pkg.sv ***
// types for the supply supervisor reset block
package ssr_pkg;
  typedef enum logic [2:0] {
    SSR_HOLD = 3'b001,
    SSR_STRETCH = 3'b010,
    SSR_RUN = 3'b100
  } ssr_state_t;
endpackage

// *** ssr_db_if.sv ***
// carrier between the top module and the manual reset debouncer
`timescale 1ns/1ps
`default_nettype none
interface ssr_db_if;
  logic raw_n;
  logic clean_n;
  modport filt (input raw_n, output clean_n);
  modport user (output raw_n, input clean_n);
endinterface
`default_nettype wire

// *** ssr_debounce.sv ***
// debouncer for the manual reset input
`timescale 1ns/1ps
`default_nettype none
`include "ssr_consts.svh"
module ssr_debounce (
  input wire logic clk,
  input wire logic rst_b,
  ssr_db_if.filt db
);
  logic [`SSR_DB_W-1:0] cnt_ff;
  logic [`SSR_DB_W-1:0] nxt_cnt;
  logic clean_ff;
  logic nxt_clean;

  // a press is passed on at once; release must stay high a full window
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_clean = clean_ff;
    if (!db.raw_n) begin
      nxt_clean = 1'b0;
      nxt_cnt = '0;
    end else if (cnt_ff < `SSR_DB_W'(`SSR_DEBOUNCE_CYC)) begin
      nxt_cnt = cnt_ff + `SSR_DB_W'(1);
    end else begin
      nxt_clean = 1'b1;
    end
  end

  // reset reads as released, matching the pulled-up idle input
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_ff <= '0;
      clean_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      clean_ff <= nxt_clean;
    end
  end

  assign db.clean_n = clean_ff;
endmodule
`default_nettype wire

// *** ssr_top.sv ***
// supply supervisor reset: stretched reset output and overvoltage flag
`timescale 1ns/1ps
`default_nettype none
`include "ssr_consts.svh"
module ssr_top #(
  parameter bit ACTIVE_HIGH = 1'b1,
  parameter logic [`SSR_CNT_W-1:0] STRETCH_CYC = `SSR_CNT_W'(`SSR_STRETCH_CYC)
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic UNDERVOLTAGE,
  input wire logic OVERVOLTAGE,
  input wire logic MANUAL_RESET_N,
  input wire logic MANUAL_RESET_CONNECTED,
  output logic RESET_OUT,
  output logic OVERVOLTAGE_FLAG_N
);
  ssr_db_if db ();
  ssr_pkg::ssr_state_t state_ff;
  ssr_pkg::ssr_state_t nxt_state;
  logic [`SSR_CNT_W-1:0] cnt_ff;
  logic [`SSR_CNT_W-1:0] nxt_cnt;
  logic cause;
  logic rst_ff;
  logic nxt_rst;
  logic ovf_ff;

  ////////////////////////////////////////////////////////////////////////
  // manual reset path: an unconnected pin reads high (pull-up)
  assign db.raw_n = MANUAL_RESET_N | ~MANUAL_RESET_CONNECTED;

  ssr_debounce ssr_debounce_inst (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .db(db)
  );

  // raw low also counts so a press acts without filter delay
  assign cause = UNDERVOLTAGE | OVERVOLTAGE | ~db.raw_n | ~db.clean_n;

  ////////////////////////////////////////////////////////////////////////
  // hold / stretch / run sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ssr_pkg::SSR_HOLD: begin
        nxt_cnt = '0;
        if (!cause) begin
          nxt_state = ssr_pkg::SSR_STRETCH;
        end
      end
      ssr_pkg::SSR_STRETCH: begin
        if (cause) begin
          nxt_state = ssr_pkg::SSR_HOLD;
          nxt_cnt = '0;
        end else if (cnt_ff >= STRETCH_CYC - `SSR_CNT_W'(1)) begin
          nxt_state = ssr_pkg::SSR_RUN;
        end else begin
          nxt_cnt = cnt_ff + `SSR_CNT_W'(1);
        end
      end
      ssr_pkg::SSR_RUN: begin
        nxt_cnt = '0;
        if (cause) begin
          nxt_state = ssr_pkg::SSR_HOLD;
        end
      end
      default: begin
        nxt_state = ssr_pkg::SSR_HOLD;
        nxt_cnt = '0;
      end
    endcase
  end

  // reset level leaves with the state; a cause asserts it the same edge
  always_comb begin
    nxt_rst = 1'b1;
    if (nxt_state == ssr_pkg::SSR_RUN) begin
      nxt_rst = 1'b0;
    end
  end

  // power-up starts in hold so the full interval runs first
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      state_ff <= ssr_pkg::SSR_HOLD;
      cnt_ff <= '0;
      rst_ff <= 1'b1;
      ovf_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      rst_ff <= nxt_rst;
      ovf_ff <= ~OVERVOLTAGE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs: polarity fixed at build time
  assign RESET_OUT = ACTIVE_HIGH ? rst_ff : ~rst_ff;
  assign OVERVOLTAGE_FLAG_N = ovf_ff;
endmodule
`default_nettype wire

// *** ssr_props.sv ***
// checker for the supply supervisor reset top
`timescale 1ns/1ps
`default_nettype none
module ssr_props #(parameter bit ACTIVE_HIGH = 1'b1, parameter logic [31:0] STRETCH_CYC = 32'h14) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic UNDERVOLTAGE,
  input wire logic OVERVOLTAGE,
  input wire logic MANUAL_RESET_N,
  input wire logic MANUAL_RESET_CONNECTED,
  input wire logic RESET_OUT,
  input wire logic OVERVOLTAGE_FLAG_N
);
  logic a, c;
  int q_ff, nxt_q;
  // cycles since last cause, saturating so a long idle never wraps
  assign a = RESET_OUT == ACTIVE_HIGH;
  assign c = UNDERVOLTAGE | OVERVOLTAGE | MANUAL_RESET_CONNECTED & !MANUAL_RESET_N;
  always_comb nxt_q = c ? 0 : q_ff + int'(q_ff < 999);
  always_ff @(posedge SYS_CLK) q_ff <= RST_B ? nxt_q : 0;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  chk_supply_cause: assert property (UNDERVOLTAGE | OVERVOLTAGE |=> a) else $error("uv");
  chk_flag_now: assert property (OVERVOLTAGE |=> !OVERVOLTAGE_FLAG_N) else $error("ov");
  chk_press_cause: assert property (c |-> ##[1:2] a) else $error("mr");
  chk_stretch_min: assert property (!a |-> q_ff >= STRETCH_CYC) else $error("lo");
  chk_stretch_max: assert property (q_ff > STRETCH_CYC + 140 |-> !a) else $error("hi");
  chk_flag_clear: assert property (!OVERVOLTAGE |=> OVERVOLTAGE_FLAG_N) else $error("fc");
  cover property ($fell(a));
  cover property ($fell(OVERVOLTAGE_FLAG_N));
  cover property (!MANUAL_RESET_N);
endmodule
bind ssr_top ssr_props #(.ACTIVE_HIGH(ACTIVE_HIGH), .STRETCH_CYC(STRETCH_CYC)) ssr_props_inst (
  .SYS_CLK(SYS_CLK), .RST_B(RST_B), .UNDERVOLTAGE(UNDERVOLTAGE), .OVERVOLTAGE(OVERVOLTAGE),
  .MANUAL_RESET_N(MANUAL_RESET_N), .MANUAL_RESET_CONNECTED(MANUAL_RESET_CONNECTED),
  .RESET_OUT(RESET_OUT), .OVERVOLTAGE_FLAG_N(OVERVOLTAGE_FLAG_N));
`default_nettype wire

// *** ssr_switch.sv ***
// push-button model that chatters after every change
`timescale 1ns/1ps
`default_nettype none
module ssr_switch (
  input wire logic clk,
  input wire logic press,
  output logic mr_n
);
  logic p_ff = 1'b0;
  logic [3:0] n_ff = 4'h8;
  // eight cycles of bounce, then the level settles
  always_ff @(posedge clk) begin
    n_ff <= press != p_ff ? 4'h0 : n_ff + {3'h0, !n_ff[3]};
    p_ff <= press;
  end
  assign mr_n = n_ff[3] ? !press : n_ff[0];
endmodule
`default_nettype wire

// *** ssr_top_tb.sv ***
// bench for the supply supervisor reset block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
module ssr_top_tb;
  int err_total = 0, cmp_count = 0, n;
  logic clk = 1'b0, rst_b = 1'b0, uv = 1'b0, ov = 1'b0, pr = 1'b0, con = 1'b1, mr_n, ro, fl_n;
  logic ro_n, fl2_n;
  always #4 clk = ~clk;
  ssr_switch ssr_switch_inst (.clk(clk), .press(pr), .mr_n(mr_n));
  ssr_top #(.STRETCH_CYC(32'h14)) ssr_top_inst (.SYS_CLK(clk), .RST_B(rst_b),
    .UNDERVOLTAGE(uv), .OVERVOLTAGE(ov), .MANUAL_RESET_N(mr_n),
    .MANUAL_RESET_CONNECTED(con), .RESET_OUT(ro), .OVERVOLTAGE_FLAG_N(fl_n));
  // active-low variant on the same stimulus, so both polarities are judged
  ssr_top #(.ACTIVE_HIGH(1'b0), .STRETCH_CYC(32'h14)) ssr_top_inst_low (.SYS_CLK(clk),
    .RST_B(rst_b), .UNDERVOLTAGE(uv), .OVERVOLTAGE(ov), .MANUAL_RESET_N(mr_n),
    .MANUAL_RESET_CONNECTED(con), .RESET_OUT(ro_n), .OVERVOLTAGE_FLAG_N(fl2_n));
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task summarize;
    $display("errors %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // bounded wait for release; a stuck reset ends the run
  task wait_rel(input int lo);
    for (n = 0; ro !== 1'b0 && n < 400; n++) cyc(1);
    if (n == 400) begin
      err_total++;
      summarize();
    end
    `CHK(n >= lo, 1'b1)
  endtask
  task t_supply;
    uv = 1'b1;
    cyc(1);
    `CHK(ro, 1'b1)
    `CHK(ro_n, 1'b0)
    uv = 1'b0;
    ov = 1'b1;
    cyc(5);
    `CHK(fl_n, 1'b0)
    ov = 1'b0;
    cyc(1);
    `CHK(fl_n, 1'b1)
    cyc(9);
    `CHK(ro, 1'b1)
    // a cause in mid-stretch must restart the full interval
    uv = 1'b1;
    cyc(1);
    uv = 1'b0;
    cyc(1);
    wait_rel(20);
  endtask
  task t_manual;
    pr = 1'b1;
    cyc(3);
    `CHK(ro, 1'b1)
    pr = 1'b0;
    wait_rel(145);
    con = 1'b0;
    pr = 1'b1;
    cyc(9);
    `CHK(ro, 1'b0)
    `CHK(ro_n, 1'b1)
  endtask
  initial begin
    cyc(6);
    rst_b = 1'b1;
    wait_rel(20);
    t_supply();
    t_manual();
    summarize();
  end
endmodule
`default_nettype wire
